// [design/rcw_pkg.sv]
/*
  package for the redundant controller watchdog arbiter: timing constants,
  register offsets, field positions, reset values and shared types.
  assumes a 40 MHz clock and a classic wishbone register bus.
*/
package rcw_pkg;

  // clock rate and documented times
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned TICK_LIMIT_S    = 5;     // most time between ticks
  localparam int unsigned HOLDOFF_S       = 300;   // watchdog off after a reset
  localparam int unsigned CHANGEOVER_MS   = 1000;  // longest changeover
  localparam int unsigned RESET_PULSE_MS  = 100;   // length of a side reset
  localparam int unsigned SETTLE_MS       = 1;     // power-up settle wait

  // derived cycle counts (longest times round down)
  localparam longint unsigned TIMEOUT_CYC   = longint'(CLK_HZ) * TICK_LIMIT_S;
  localparam longint unsigned HOLDOFF_CYC   = longint'(CLK_HZ) * HOLDOFF_S;
  localparam longint unsigned CHANGE_CYC    = longint'(CLK_HZ) / 1000 * CHANGEOVER_MS;
  localparam longint unsigned RSTPULSE_CYC  = longint'(CLK_HZ) / 1000 * RESET_PULSE_MS;
  localparam longint unsigned SETTLE_CYC    = longint'(CLK_HZ) / 1000 * SETTLE_MS;

  // counter width wide enough for the hold-off count
  localparam int unsigned CNT_W = 34;

  // register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;  // control: switch request, redundant
  localparam logic [3:0] REG_STATUS = 4'h4;  // status: active side, watchdogs
  localparam logic [3:0] REG_CAUSE  = 4'h8;  // last changeover cause

  // control field positions
  localparam int unsigned CTRL_SWREQ = 0;  // write 1: software changeover request
  localparam int unsigned CTRL_REDUN = 1;  // 1 = two controllers fitted
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

  // selector encoding
  typedef enum logic [1:0] {
    RCW_SEL_AUTO = 2'b00,
    RCW_SEL_A    = 2'b01,
    RCW_SEL_B    = 2'b10
  } rcw_sel_type;

  // per-side inputs from a controller and the chassis
  typedef struct packed {
    logic tick;      // watchdog kick
    logic online;    // side flagged on-line
    logic present;   // bus controller card present
    logic avail;     // controller assembly available / powered
  } rcw_side_in_type;

  // per-side outputs
  typedef struct packed {
    logic reset;     // power-reset to this side
    logic wd_exp;    // watchdog expired
    logic wd_en;     // watchdog supervising
  } rcw_side_out_type;

  // wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [3:0]  adr;
    logic [31:0] dat;
  } rcw_wb_req_type;

endpackage

// [design/rcw_sync.sv]
/*
  two flip-flop synchroniser for a bundle of pin levels.
  assumes the inputs are asynchronous to clk_i.
*/
module rcw_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  import rcw_pkg::*;

  // all state of the synchroniser
  typedef struct packed {
    logic [W-1:0] s1;  // first stage, read only by the second
    logic [W-1:0] s2;  // second stage
  } rcw_sync_st_type;

  rcw_sync_st_type st_r;
  rcw_sync_st_type st_nxt;

  // shift the pins through two stages
  always_comb begin
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  // register the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule

// [design/rcw_side_wd.sv]
/*
  watchdog and power-reset path for one controller side.
  assumes tick, reset-request and inhibit inputs are synchronous pulses
  or levels on clk_i.
*/
module rcw_side_wd #(
  parameter longint unsigned TIMEOUT = rcw_pkg::TIMEOUT_CYC,
  parameter longint unsigned HOLDOFF = rcw_pkg::HOLDOFF_CYC,
  parameter longint unsigned RSTLEN  = rcw_pkg::RSTPULSE_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      tick_i,     // synchronised tick level
  input  wire logic                      inhibit_i,  // other side forced active
  input  wire logic                      rst_req_i,  // reset button request
  output rcw_pkg::rcw_side_out_type      out_o
);
  import rcw_pkg::*;

  // side state
  typedef struct packed {
    logic [CNT_W-1:0] cnt;      // timeout count
    logic [CNT_W-1:0] hold;     // hold-off count, nonzero = disabled
    logic [CNT_W-1:0] rlen;     // reset pulse count
    logic             tick_d;   // previous tick for edge find
    logic             expired;  // timeout seen
  } rcw_wd_st_type;

  rcw_wd_st_type st_r;
  rcw_wd_st_type st_nxt;
  logic          tick_edge;  // rising edge of the tick
  logic          fire;       // start a reset of this side

  // timeout, hold-off and reset pulse
  always_comb begin
    st_nxt        = st_r;
    tick_edge     = tick_i & ~st_r.tick_d;
    st_nxt.tick_d = tick_i;
    fire          = 1'b0;
    if (st_r.rlen != '0) begin
      // reset pulse in progress
      st_nxt.rlen = st_r.rlen - CNT_W'(1);
      if (st_r.rlen == CNT_W'(1)) begin
        st_nxt.hold = CNT_W'(HOLDOFF);  // [RULE3]
        st_nxt.cnt  = '0;
      end
    end else if (rst_req_i) begin
      fire = 1'b1;  // [RULE10]
    end else if (st_r.hold != '0) begin
      st_nxt.hold = st_r.hold - CNT_W'(1);  // [RULE3]
      st_nxt.cnt  = '0;
    end else if (inhibit_i) begin
      st_nxt.cnt     = '0;  // [RULE4]
      st_nxt.expired = 1'b0;
    end else if (tick_edge) begin
      st_nxt.cnt     = '0;  // [RULE17]
      st_nxt.expired = 1'b0;
    end else if (st_r.cnt >= CNT_W'(TIMEOUT - 1)) begin
      st_nxt.expired = 1'b1;  // [RULE2]
      fire           = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + CNT_W'(1);
    end
    if (fire) begin
      st_nxt.rlen = CNT_W'(RSTLEN);
      st_nxt.cnt  = '0;
    end
  end

  // register the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r      <= '0;
      st_r.hold <= CNT_W'(HOLDOFF);  // [RULE3]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_o.reset  = (st_r.rlen != '0);
  assign out_o.wd_exp = st_r.expired;
  assign out_o.wd_en  = (st_r.hold == '0) & (st_r.rlen == '0) & ~inhibit_i;
endmodule

// [design/rcw_arbiter.sv]
/*
  redundant controller watchdog arbiter: two independent watchdogs and
  reset paths, active-side selection, selector and reset buttons, and a
  wishbone register slave.
  assumes front panel and controller inputs are asynchronous pins and the
  wishbone master is on clk_i.
*/
// The Wishbone slave port and the placing of the registers were left to the implementer.
// Notes on behaviour
// RULE1: independent watchdog and reset path per side
// RULE2: tick every five seconds, else reset side
// RULE3: watchdog disabled five minutes after side reset
// RULE4: forcing one side disables other's watchdog
// RULE5: changeover on unavailable, expiry, offline, request
// RULE6: auto changeover needs auto, card, watchdog, online
// RULE7: standby flags online only after sync
// RULE8: changeover completes within one second
// RULE9: forced selector switches active side immediately
// RULE10: each reset button resets its side only
// RULE11: decode auto, force A, force B
// RULE12: single controller system always uses side A
// RULE13: no auto changeover while a side forced
// RULE14: redundant power-up in auto picks A
// RULE15: A unpowered in auto stays standby
// RULE16: audible cutoff switch has no effect
// RULE17: each tick restarts its side's timeout
module rcw_arbiter #(
  parameter longint unsigned TIMEOUT = rcw_pkg::TIMEOUT_CYC,
  parameter longint unsigned HOLDOFF = rcw_pkg::HOLDOFF_CYC,
  parameter longint unsigned RSTLEN  = rcw_pkg::RSTPULSE_CYC,
  parameter longint unsigned CHANGE  = rcw_pkg::CHANGE_CYC,
  parameter longint unsigned SETTLE  = rcw_pkg::SETTLE_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [3:0]                wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // controller sides, pins
  input  wire rcw_pkg::rcw_side_in_type  side_a_i,
  input  wire rcw_pkg::rcw_side_in_type  side_b_i,
  // front panel, pins
  input  wire logic [1:0]                selector_i,
  input  wire logic                      reset_btn_a_i,
  input  wire logic                      reset_btn_b_i,
  input  wire logic                      audible_cutoff_switch_i,
  // outputs
  output logic                           side_a_reset_o,
  output logic                           side_b_reset_o,
  output logic                           active_a_o,
  output logic                           active_b_o,
  output logic                           standby_o
);
  import rcw_pkg::*;

  // arbiter states, one-hot
  typedef enum logic [4:0] {
    ST_SETTLE = 5'b00001,  // power-up wait
    ST_A      = 5'b00010,  // side A active
    ST_B      = 5'b00100,  // side B active
    ST_SWITCH = 5'b01000,  // changeover under way
    ST_IDLE   = 5'b10000   // system in standby
  } rcw_state_type;

  // whole module state
  typedef struct packed {
    rcw_state_type    state;
    logic             tgt_b;     // changeover target is B
    logic [CNT_W-1:0] cnt;       // settle / changeover count
    logic             redun;     // two controllers fitted
    logic             swreq;     // pending software request
    logic [2:0]       cause;     // last changeover cause
    logic             ack;
    logic [31:0]      rdat;
    logic [4:0]       outs;      // reset a, reset b, act a, act b, standby
  } rcw_st_type;

  rcw_st_type       st_r;
  rcw_st_type       st_nxt;
  rcw_side_in_type  a_s;        // synchronised side A
  rcw_side_in_type  b_s;        // synchronised side B
  logic [1:0]       sel_s;      // synchronised selector
  logic             btn_a_s;
  logic             btn_b_s;
  rcw_side_out_type wd_a;
  rcw_side_out_type wd_b;
  logic             force_a;
  logic             force_b;
  logic             auto_mode;
  logic             fail_a;     // side A failure events
  logic             fail_b;
  logic             ok_a;       // side A fit to take over
  logic             ok_b;
  logic             wb_hit;
  logic             rst_a;
  logic             rst_b;

  // pins pass two flip-flops before use; the cutoff switch is left unread
  rcw_sync #(.W(12)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({side_a_i, side_b_i, selector_i, reset_btn_a_i, reset_btn_b_i}),
    .q_o   ({a_s, b_s, sel_s, btn_a_s, btn_b_s})
  );  // [RULE16]

  // selector decode
  always_comb begin
    force_a   = (sel_s == RCW_SEL_A);  // [RULE11]
    force_b   = (sel_s == RCW_SEL_B);  // [RULE11]
    auto_mode = ~force_a & ~force_b;
  end

  assign rst_a = btn_a_s;  // [RULE10]
  assign rst_b = btn_b_s;  // [RULE10]

  // side A watchdog, disabled while B is forced
  rcw_side_wd #(.TIMEOUT(TIMEOUT), .HOLDOFF(HOLDOFF), .RSTLEN(RSTLEN)) u_wd_a (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (a_s.tick),
    .inhibit_i (force_b),  // [RULE4]
    .rst_req_i (rst_a),
    .out_o     (wd_a)
  );  // [RULE1]

  // side B watchdog, disabled while A is forced
  rcw_side_wd #(.TIMEOUT(TIMEOUT), .HOLDOFF(HOLDOFF), .RSTLEN(RSTLEN)) u_wd_b (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (b_s.tick),
    .inhibit_i (force_a),  // [RULE4]
    .rst_req_i (rst_b),
    .out_o     (wd_b)
  );  // [RULE1]

  // changeover causes and readiness of each side
  always_comb begin
    fail_a = ~a_s.avail | wd_a.wd_exp | ~a_s.online;  // [RULE5]
    fail_b = ~b_s.avail | wd_b.wd_exp | ~b_s.online;  // [RULE5]
    ok_a   = a_s.present & ~wd_a.wd_exp & a_s.online;  // [RULE6] [RULE7]
    ok_b   = b_s.present & ~wd_b.wd_exp & b_s.online;  // [RULE6] [RULE7]
  end

  assign wb_hit = wb_cyc_i & wb_stb_i & ~st_r.ack;

  // arbiter, register file and output image
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = wb_hit;
    // register reads, unmapped reads zero
    st_nxt.rdat = '0;
    if (wb_hit && !wb_we_i) begin
      unique case (wb_adr_i)
        REG_CTRL:   st_nxt.rdat = {30'h0000_0000, st_r.redun, st_r.swreq};
        REG_STATUS: st_nxt.rdat = {24'h00_0000, wd_b.wd_en, wd_a.wd_en,
                                   wd_b.wd_exp, wd_a.wd_exp, sel_s,
                                   st_r.outs[1], st_r.outs[2]};
        REG_CAUSE:  st_nxt.rdat = {29'h0000_0000, st_r.cause};
        default:    st_nxt.rdat = '0;
      endcase
    end
    // state machine
    unique case (st_r.state)
      ST_SETTLE: begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
        if (force_b && st_r.redun) begin
          st_nxt.state = ST_B;  // [RULE15]
        end else if (st_r.cnt >= CNT_W'(SETTLE)) begin
          if (!st_r.redun || force_a || a_s.avail) begin
            st_nxt.state = ST_A;  // [RULE14] [RULE12]
          end else begin
            st_nxt.state = ST_IDLE;  // [RULE15]
          end
        end
      end
      ST_IDLE: begin
        if (!st_r.redun || force_a || a_s.avail) begin
          st_nxt.state = ST_A;
        end else if (force_b) begin
          st_nxt.state = ST_B;  // [RULE15]
        end
      end
      ST_A: begin
        if (!st_r.redun) begin
          st_nxt.swreq = 1'b0;  // [RULE12]
        end else if (force_b) begin
          st_nxt.state = ST_B;  // [RULE9]
        end else if (auto_mode && (fail_a || st_r.swreq) && ok_b) begin
          // [RULE6] [RULE13]
          st_nxt.state = ST_SWITCH;
          st_nxt.tgt_b = 1'b1;
          st_nxt.cnt   = '0;
          st_nxt.cause = {st_r.swreq, wd_a.wd_exp, ~a_s.avail | ~a_s.online};
        end
      end
      ST_B: begin
        if (!st_r.redun || force_a) begin
          st_nxt.state = ST_A;  // [RULE9] [RULE12]
        end else if (auto_mode && (fail_b || st_r.swreq) && ok_a) begin
          // [RULE6] [RULE13]
          st_nxt.state = ST_SWITCH;
          st_nxt.tgt_b = 1'b0;
          st_nxt.cnt   = '0;
          st_nxt.cause = {st_r.swreq, wd_b.wd_exp, ~b_s.avail | ~b_s.online};
        end
      end
      ST_SWITCH: begin
        // brief break before make, bounded well under a second
        st_nxt.cnt   = st_r.cnt + CNT_W'(1);
        st_nxt.swreq = 1'b0;
        if (force_a) begin
          st_nxt.state = ST_A;  // [RULE9]
        end else if (force_b) begin
          st_nxt.state = ST_B;  // [RULE9]
        end else if (st_r.cnt >= CNT_W'(CHANGE - 1) || st_r.cnt >= CNT_W'(SETTLE)) begin
          st_nxt.state = st_r.tgt_b ? ST_B : ST_A;  // [RULE8]
        end
      end
      default: st_nxt.state = ST_SETTLE;
    endcase
    // register writes come last, so a request in the cycle of a clear wins
    if (wb_hit && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      st_nxt.redun = wb_dat_i[CTRL_REDUN];
      if (wb_dat_i[CTRL_SWREQ]) begin
        st_nxt.swreq = 1'b1;  // [RULE5]
      end
    end
    // output image: active and standby from next state, side resets from the watchdogs
    st_nxt.outs = {wd_a.reset, wd_b.reset, (st_nxt.state == ST_A),
                   (st_nxt.state == ST_B), (st_nxt.state == ST_IDLE)};
  end

  // register all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r       <= '0;
      st_r.state <= ST_SETTLE;
      st_r.redun <= CTRL_RESET[CTRL_REDUN];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o       = st_r.rdat;
  assign wb_ack_o       = st_r.ack;
  assign side_a_reset_o = st_r.outs[4];
  assign side_b_reset_o = st_r.outs[3];
  assign active_a_o     = st_r.outs[2];
  assign active_b_o     = st_r.outs[1];
  assign standby_o      = st_r.outs[0];
endmodule

// [testbench/rcw_arbiter_props.sv]
/*
  checker for the redundant controller watchdog arbiter top ports.
  assumes one clock, synchronous active high reset and the short bench
  counts (timeout 100, hold-off 50, reset pulse 4 cycles).
*/
module rcw_arbiter_props
  import rcw_pkg::*;
#(
  parameter longint unsigned TIMEOUT = 100,
  parameter longint unsigned HOLDOFF = 50,
  parameter longint unsigned RSTLEN  = 4
) (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_ack_o,
  input wire rcw_side_in_type side_a_i,
  input wire logic [1:0]      selector_i,
  input wire logic            reset_btn_a_i,
  input wire logic            side_a_reset_o,
  input wire logic            active_a_o,
  input wire logic            active_b_o,
  input wire logic            standby_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic            tick_q_r;   // last tick level of side a
  logic            tick_rise;  // tick edge seen this cycle
  longint unsigned qa_r;       // cycles since last tick
  longint unsigned qu_r;       // cycles since side a last ticked, was reset or inhibited, hold-off included
  longint unsigned ba_r;       // cycles since button a was last held

  assign tick_rise = side_a_i.tick & ~tick_q_r;

  // age counters; inhibit and side resets restart the unfed count
  always_ff @(posedge clk_i) begin
    tick_q_r <= side_a_i.tick;
    qa_r     <= (rst_i || tick_rise) ? '0 : qa_r + 1;
    qu_r     <= (rst_i || tick_rise || side_a_reset_o || selector_i == RCW_SEL_B) ? '0 : qu_r + 1;
    ba_r     <= (rst_i || reset_btn_a_i) ? '0 : ba_r + 1;
  end

  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  AST_ONE_ACTIVE: assert property (!(active_a_o && active_b_o))
    else $error("both sides active");
  AST_STANDBY: assert property (standby_o |-> !active_a_o && !active_b_o)
    else $error("standby while a side is active");
  AST_RST_PULSE_A: assert property ($rose(side_a_reset_o) |-> side_a_reset_o [*4] ##1 !side_a_reset_o)
    else $error("side a reset pulse length wrong");
  AST_BTN_A: assert property (reset_btn_a_i [*3] |-> ##[0:6] side_a_reset_o)
    else $error("button a gave no reset");
  AST_WD_LATE: assert property (qu_r <= TIMEOUT + HOLDOFF + RSTLEN + 16)
    else $error("side a not reset after missed ticks");
  AST_WD_EARLY: assert property ($rose(side_a_reset_o) |-> (qa_r + 4 >= TIMEOUT) || (ba_r < 8))
    else $error("side a reset although ticked recently");
  AST_FORCE_A: assert property ((selector_i == RCW_SEL_A) [*8] |-> ##[0:24] active_a_o)
    else $error("forced side a not active");
  AST_FORCE_B: assert property ((selector_i == RCW_SEL_B) [*8] |-> ##[0:24] active_b_o)
    else $error("forced side b not active");
  AST_CHANGE: assert property (($fell(active_a_o) || $fell(active_b_o)) |-> ##[1:40] (active_a_o || active_b_o))
    else $error("changeover not complete in time");

  COV_AUTO_CHANGE: cover property ($rose(active_b_o) && selector_i == RCW_SEL_AUTO);
  COV_WD_RESET: cover property ($rose(side_a_reset_o) && ba_r > 8);
  COV_STANDBY: cover property ($rose(standby_o) && selector_i == RCW_SEL_AUTO);
endmodule

bind rcw_arbiter rcw_arbiter_props #(.TIMEOUT(TIMEOUT), .HOLDOFF(HOLDOFF), .RSTLEN(RSTLEN)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .side_a_i(side_a_i), .selector_i(selector_i), .reset_btn_a_i(reset_btn_a_i),
  .side_a_reset_o(side_a_reset_o), .active_a_o(active_a_o), .active_b_o(active_b_o),
  .standby_o(standby_o)
);

// [testbench/rcw_ctrl_model.sv]
/*
  behavioural model of one system controller as seen by the arbiter.
  assumes the bench steers ticking, readiness, presence and power.
*/
module rcw_ctrl_model
  import rcw_pkg::*;
#(
  parameter int PERIOD = 60,  // cycles between ticks
  parameter int SYNC   = 20   // file sync time after a reset
) (
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      side_reset_i,  // reset from the arbiter
  input  wire logic      run_i,         // software alive and ticking
  input  wire logic      ready_i,       // software wants on-line
  input  wire logic      present_i,
  input  wire logic      avail_i,
  output rcw_side_in_type side_o
);
  int tcnt;  // tick phase
  int scnt;  // sync progress

  // a reset restarts both the tick phase and the file sync
  always_ff @(posedge clk_i) begin
    if (rst_i || side_reset_i) begin
      tcnt <= 0;
      scnt <= 0;
    end else begin
      tcnt <= (tcnt == PERIOD - 1) ? 0 : tcnt + 1;
      if (scnt < SYNC) scnt <= scnt + 1;
    end
  end

  // outputs follow the model state, never a stale level
  always_comb begin
    side_o.tick    = run_i && avail_i && tcnt == 1;
    side_o.online  = ready_i && avail_i && scnt == SYNC;
    side_o.present = present_i;
    side_o.avail   = avail_i;
  end
endmodule

// [testbench/tb_top.sv]
/*
  self-checking bench for the watchdog arbiter with two controller models.
  assumes shortened counts: timeout 100, hold-off 50, pulse 4, settle 8.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rcw_pkg::*;

  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [3:0]  adr = '0;
  logic [31:0] dat = '0, rdat, wb_dat_o;
  logic wb_ack_o, ra, rb, aa, ab, sb;
  logic [1:0] sel_sw = RCW_SEL_AUTO;  // front panel selector
  logic btn_a = 0, btn_b = 0, audible_cutoff_switch = 0;
  logic run_a = 1, run_b = 1, rdy_a = 1, rdy_b = 1, av_a = 1;
  logic av_b = 1, pr_a = 1, pr_b = 1;  // card presence and power per side
  logic [3:0] wsel = 4'hf;  // byte lanes of the next request
  rcw_side_in_type sa, sbi;
  int errors = 0, total_checks = 0, cycles = 0;

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  rcw_arbiter #(.TIMEOUT(100), .HOLDOFF(50), .RSTLEN(4), .CHANGE(40), .SETTLE(8)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(wsel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .side_a_i(sa), .side_b_i(sbi), .selector_i(sel_sw), .reset_btn_a_i(btn_a),
    .reset_btn_b_i(btn_b), .audible_cutoff_switch_i(audible_cutoff_switch), .side_a_reset_o(ra),
    .side_b_reset_o(rb), .active_a_o(aa), .active_b_o(ab), .standby_o(sb));
  rcw_ctrl_model mdl_a (.clk_i(clk_i), .rst_i(rst_i), .side_reset_i(ra), .run_i(run_a),
    .ready_i(rdy_a), .present_i(pr_a), .avail_i(av_a), .side_o(sa));
  rcw_ctrl_model mdl_b (.clk_i(clk_i), .rst_i(rst_i), .side_reset_i(rb), .run_i(run_b),
    .ready_i(rdy_b), .present_i(pr_b), .avail_i(av_b), .side_o(sbi));

  task wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("unexpected at %0t: run timed out", $time);
      wrap_up();
    end
  end

  task chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    // wait for the answer however long; only the hang guard ends this
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask

  task wait_act(input logic a, input logic b, input int lim, input string msg);
    int n;
    n = 0;
    while (!(aa === a && ab === b) && n < lim) begin @(posedge clk_i); n++; end
    chk(aa === a && ab === b, msg);
  endtask

  task t_start;
    wait_act(1, 0, 40, "side a not active after power-up");
    // a control write without lane 0 must leave the register alone
    wsel <= 4'he;
    wb(1, REG_CTRL, 32'h0000_0001);
    wsel <= 4'hf;
    wb(0, REG_CTRL, '0);
    chk(rdat === CTRL_RESET, "control reset value");
    wb(0, 4'hc, '0);
    chk(rdat === 32'h0000_0000, "unmapped read not zero");
    wb(0, REG_STATUS, '0);
    chk(rdat[3:0] === 4'h1, "status side or selector");
  endtask

  task t_watchdog;
    int n, bad;
    bad = 0;
    repeat (250) begin @(posedge clk_i); if (ra !== 1'b0) bad = 1; end
    chk(!bad, "reset despite regular ticks");
    run_a <= 0;
    n = 0;
    while (ra !== 1'b1 && n < 130) begin @(posedge clk_i); n++; end
    chk(ra === 1'b1, "no reset after missed ticks");
    chk(rb === 1'b0, "other side reset too");
    run_a <= 1;
    wait_act(0, 1, 60, "no changeover after expiry");
    wb(0, REG_STATUS, '0);
    chk(rdat[6] === 1'b0, "watchdog a on during hold-off");
    repeat (60) @(posedge clk_i);
    wb(0, REG_STATUS, '0);
    chk(rdat[6] === 1'b1, "watchdog a not back after hold-off");
  endtask

  task t_swreq;
    wb(1, REG_CTRL, 32'h0000_0003);
    wait_act(1, 0, 60, "software request ignored");
    pr_b <= 0;
    wb(1, REG_CTRL, 32'h0000_0003);
    repeat (40) @(posedge clk_i);
    chk(aa === 1'b1 && ab === 1'b0, "changeover to absent standby card");
    pr_b <= 1; rdy_b <= 0;
    wb(1, REG_CTRL, 32'h0000_0003);
    repeat (80) @(posedge clk_i);
    chk(aa === 1'b1 && ab === 1'b0, "changeover to off-line standby");
    rdy_b <= 1;
    wait_act(0, 1, 60, "pending request not served");
    rdy_b <= 0;
    wait_act(1, 0, 60, "active off-line kept");
    rdy_b <= 1;
  endtask

  task t_forced;
    int bad;
    bad = 0;
    rdy_b <= 0; run_b <= 0; sel_sw <= RCW_SEL_B;
    wait_act(0, 1, 24, "forced b not taken");
    run_a <= 0;
    repeat (200) begin @(posedge clk_i); if (ra !== 0 || aa !== 0 || ab !== 1) bad = 1; end
    chk(!bad, "inhibit or forced hold broken");
    sel_sw <= RCW_SEL_A;
    wait_act(1, 0, 24, "forced a not taken");
    run_a <= 1; run_b <= 1; rdy_b <= 1; sel_sw <= RCW_SEL_AUTO;
    repeat (80) @(posedge clk_i);
  endtask

  task t_button(input logic side);
    int n, bad;
    n = 0;
    bad = 0;
    audible_cutoff_switch <= ~audible_cutoff_switch;
    if (side) btn_b <= 1; else btn_a <= 1;
    while ((side ? rb : ra) !== 1'b1 && n < 10) begin
      @(posedge clk_i);
      n++;
      if ((side ? ra : rb) !== 1'b0) bad = 1;
    end
    btn_a <= 0; btn_b <= 0;
    chk((side ? rb : ra) === 1'b1 && !bad, "button reset wrong side");
    repeat (40) @(posedge clk_i);
  endtask

  task t_single;
    rdy_a <= 0;
    wait_act(0, 1, 60, "a off-line did not hand over");
    wb(1, REG_CTRL, '0);
    wait_act(1, 0, 60, "single mode not on a");
    rdy_a <= 1;
  endtask

  task t_unpowered;
    av_a <= 0; rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    repeat (40) @(posedge clk_i);
    chk(sb === 1'b1 && aa === 1'b0 && ab === 1'b0, "did not stay in standby");
    sel_sw <= RCW_SEL_B;
    wait_act(0, 1, 24, "forced b after power-up");
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    t_start();
    t_watchdog();
    t_swreq();
    t_forced();
    t_button(0);
    t_button(1);
    t_single();
    t_unpowered();
    wrap_up();
  end
endmodule
